// ===== fmpm_cfg.svh
`ifndef FMPM_CFG_SVH
`define FMPM_CFG_SVH

// Configuration space byte offsets
`define FMPM_CAP_OFFSET 8'h46
`define FMPM_CSR_OFFSET 8'h48
`define FMPM_GCTL_OFFSET 8'h4c

// Reset values
`define FMPM_CAP_RESET 16'h7e02
`define FMPM_CSR_RESET 16'h0000
`define FMPM_GCTL_RESET 1'h0

// Capability word field positions
`define FMPM_CAP_COLD_POS 15
`define FMPM_CAP_MASK_HI 14
`define FMPM_CAP_MASK_LO 11
`define FMPM_CAP_D2_POS 10
`define FMPM_CAP_D1_POS 9
`define FMPM_CAP_AUX_HI 8
`define FMPM_CAP_AUX_LO 6
`define FMPM_CAP_DSI_POS 5
`define FMPM_CAP_RSVD_POS 4
`define FMPM_CAP_CLK_POS 3
`define FMPM_CAP_REV_HI 2
`define FMPM_CAP_REV_LO 0

// Capability field values
`define FMPM_WAKE_MASK 4'hf
`define FMPM_AUX_SELF 3'h0
`define FMPM_AUX_55MA 3'h1
`define FMPM_SPEC_REV 3'h2

// Control/status field positions
`define FMPM_CSR_FLAG_POS 15
`define FMPM_CSR_EN_POS 8
`define FMPM_CSR_STATE_HI 1
`define FMPM_CSR_STATE_LO 0

// General control field position
`define FMPM_GCTL_COLD_POS 4

`endif

// ===== fmpm_pkg.sv
package fmpm_pkg;

  // Power state encoding
  typedef enum logic [1:0] {
    fmpm_d0 = 2'h0,
    fmpm_d1 = 2'h1,
    fmpm_d2 = 2'h2,
    fmpm_d3hot = 2'h3
  } fmpm_power_type;

  // Configuration access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } fmpm_cfg_req_type;

  // Configuration access answer
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } fmpm_cfg_rsp_type;

endpackage : fmpm_pkg

// ===== fmpm_sticky_flag.sv
`timescale 1ns/1ps

module fmpm_sticky_flag (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic set,
  input wire logic clear,
  output logic flag_d,
  output logic flag_q
);

  // Set wins over a clear in the same cycle
  always_comb begin
    flag_d = set | (flag_q & ~clear);
  end

  // Cleared by the asynchronous reset, or by clear when set is low
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

endmodule : fmpm_sticky_flag

// ===== fmpm_regs.sv
`timescale 1ns/1ps
`include "fmpm_cfg.svh"

module fmpm_regs (
  input wire logic clk,
  input wire logic reset_n,
  input fmpm_pkg::fmpm_cfg_req_type cfg_req,
  output fmpm_pkg::fmpm_cfg_rsp_type cfg_rsp_q,
  input wire logic wake_detect,
  output logic wake_assert_q,
  output fmpm_pkg::fmpm_power_type power_state_q,
  output logic internal_reset_q,
  output logic cold_wake_config_q
);

  localparam logic [7:0] cap_off = `FMPM_CAP_OFFSET;
  localparam logic [7:0] csr_off = `FMPM_CSR_OFFSET;
  localparam logic [7:0] gctl_off = `FMPM_GCTL_OFFSET;
  localparam logic [15:0] csr_reset = `FMPM_CSR_RESET;

  // Write to byte k of the register at offset off
  // Dword match plus the lane enable; address bits 1:0 are ignored
  function automatic logic byte_write(fmpm_pkg::fmpm_cfg_req_type r, logic [7:0] off, logic [1:0] k);
    logic [1:0] lane;
    lane = off[1:0] + k;
    return r.valid & r.write & (r.addr[7:2] == off[7:2]) & r.byte_en[lane];
  endfunction : byte_write

  // Place a 16-bit register in its half of the dword
  function automatic logic [31:0] place16(logic [15:0] v, logic [7:0] off);
    return off[1] ? {v, 16'h0000} : {16'h0000, v};
  endfunction : place16

  logic cold_wake_config_bit;
  logic wake_event_enable_q;
  logic wake_event_enable_d;
  logic wake_event_flag;
  logic wake_flag_d;
  logic flag_clear;
  logic [15:0] cap_word;
  logic [15:0] csr_word;
  logic [31:0] rdata_d;
  fmpm_pkg::fmpm_power_type power_state_d;

  assign cold_wake_config_bit = cold_wake_config_q;

  // General control bit 4 storage
  // Other general control bits live outside this bank and read zero here
  // general control write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cold_wake_config_q <= `FMPM_GCTL_RESET;
    end else if (byte_write(cfg_req, gctl_off, 2'h0)) begin
      cold_wake_config_q <= cfg_req.wdata[`FMPM_GCTL_COLD_POS];
    end
  end

  // Capability word, fixed fields and the mirrored bit
  // Only bit 15 and the current field follow the control bit
  always_comb begin
    cap_word = 16'h0000;
    cap_word[`FMPM_CAP_COLD_POS] = cold_wake_config_bit;
    cap_word[`FMPM_CAP_MASK_HI:`FMPM_CAP_MASK_LO] = `FMPM_WAKE_MASK;
    cap_word[`FMPM_CAP_D2_POS] = 1'b1;
    cap_word[`FMPM_CAP_D1_POS] = 1'b1;
    cap_word[`FMPM_CAP_AUX_HI:`FMPM_CAP_AUX_LO] = cold_wake_config_bit ? `FMPM_AUX_55MA : `FMPM_AUX_SELF;
    cap_word[`FMPM_CAP_DSI_POS] = 1'b0;
    cap_word[`FMPM_CAP_RSVD_POS] = 1'b0;
    cap_word[`FMPM_CAP_CLK_POS] = 1'b0;
    cap_word[`FMPM_CAP_REV_HI:`FMPM_CAP_REV_LO] = `FMPM_SPEC_REV;
  end

  // write one clears flag
  // Flag and enable sit in lane 1 of the low half of their dword
  assign flag_clear = byte_write(cfg_req, csr_off, 2'h1) & cfg_req.wdata[`FMPM_CSR_FLAG_POS];

  // Wake status flag, set by the core, cleared by a write of one
  fmpm_sticky_flag u_wake_flag (
    .clk(clk),
    .reset_n(reset_n),
    .set(wake_detect),
    .clear(flag_clear),
    .flag_d(wake_flag_d),
    .flag_q(wake_event_flag)
  );

  // Next values of enable and power state
  always_comb begin
    wake_event_enable_d = wake_event_enable_q;
    power_state_d = power_state_q;
    if (byte_write(cfg_req, csr_off, 2'h1)) begin
      wake_event_enable_d = cfg_req.wdata[`FMPM_CSR_EN_POS];
    end
    if (byte_write(cfg_req, csr_off, 2'h0)) begin
      power_state_d = fmpm_pkg::fmpm_power_type'(cfg_req.wdata[`FMPM_CSR_STATE_HI:`FMPM_CSR_STATE_LO]);
    end
  end

  // Control fields, cleared by the global reset alone
  // global reset only
  // kept through internal reset
  // Any other reset source in the device leaves these alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_event_enable_q <= csr_reset[`FMPM_CSR_EN_POS];
      power_state_q <= fmpm_pkg::fmpm_d0;
    end else begin
      wake_event_enable_q <= wake_event_enable_d;
      power_state_q <= power_state_d;
    end
  end

  // Pulse for the core when leaving D3hot for D0
  // Raised on the edge that writes D0, so it stands beside the new state
  // The core uses it; nothing in this bank is cleared by it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      internal_reset_q <= 1'b0;
    end else begin
      internal_reset_q <= (power_state_q == fmpm_pkg::fmpm_d3hot) && (power_state_d == fmpm_pkg::fmpm_d0);
    end
  end

  // Wake output from next values, so it never lags a clear
  // A detection while disabled stays pending in the flag for a later enable
  // wake output gating
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wake_assert_q <= 1'b0;
    end else begin
      wake_assert_q <= wake_flag_d & wake_event_enable_d;
    end
  end

  // Control/status word as read
  // no data register
  always_comb begin
    csr_word = 16'h0000;
    csr_word[`FMPM_CSR_FLAG_POS] = wake_event_flag;
    csr_word[`FMPM_CSR_EN_POS] = wake_event_enable_q;
    csr_word[`FMPM_CSR_STATE_HI:`FMPM_CSR_STATE_LO] = power_state_q;
  end

  // Read data decode, unmapped dwords read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (cfg_req.valid && !cfg_req.write) begin
      if (cfg_req.addr[7:2] == cap_off[7:2]) begin
        rdata_d = place16(cap_word, cap_off);
      end else if (cfg_req.addr[7:2] == csr_off[7:2]) begin
        rdata_d = place16(csr_word, csr_off);
      end else if (cfg_req.addr[7:2] == gctl_off[7:2]) begin
        rdata_d = {27'h0, cold_wake_config_q, 4'h0};
      end
    end
  end

  // Answer register, one cycle after every request
  // Writes and unmapped dwords answer with zero read data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rsp_q <= '0;
    end else begin
      cfg_rsp_q.ack <= cfg_req.valid;
      cfg_rsp_q.rdata <= rdata_d;
    end
  end

  // All checks run on the bus clock and pause while the global reset is low
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Read of the capability and control/status registers
  sequence cap_read;
    cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == cap_off[7:2];
  endsequence

  sequence csr_read;
    cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == csr_off[7:2];
  endsequence

  // Write one to the flag with no detection
  sequence flag_w1c;
    flag_clear && !wake_detect;
  endsequence

  // Read of the general control dword
  sequence gctl_read;
    cfg_req.valid && !cfg_req.write && cfg_req.addr[7:2] == gctl_off[7:2];
  endsequence

  // Power state leaving D3hot for D0 on consecutive samples
  sequence d3hot_exit;
    power_state_q == fmpm_pkg::fmpm_d3hot ##1 power_state_q == fmpm_pkg::fmpm_d0;
  endsequence

  // Capability word as read
  a_cold_mirror: assert property (cap_read |=> cfg_rsp_q.rdata[31] == $past(cold_wake_config_q))
    else $error("cold wake capability does not mirror control bit");
  a_wake_mask: assert property (cap_read |=> cfg_rsp_q.ack && cfg_rsp_q.rdata[30:27] == 4'hf)
    else $error("wake state mask not 1111b");
  a_doze_bits: assert property (cap_read |=> cfg_rsp_q.rdata[26:25] == 2'h3)
    else $error("doze support bits not set");
  a_aux_current: assert property (cap_read |=> cfg_rsp_q.rdata[24:22] == (cfg_rsp_q.rdata[31] ? 3'h1 : 3'h0))
    else $error("auxiliary current field wrong");
  a_dsi_zero: assert property (cap_read |=> !cfg_rsp_q.rdata[21])
    else $error("special init bit set");
  a_cap_rsvd: assert property (cap_read |=> !cfg_rsp_q.rdata[20])
    else $error("capability reserved bit set");
  a_clock_bit: assert property (cap_read |=> !cfg_rsp_q.rdata[19])
    else $error("wake clock bit set");
  a_spec_rev: assert property (cap_read |=> cfg_rsp_q.rdata[18:16] == 3'h2)
    else $error("revision field not 010b");

  // Control fields and the internal reset
  a_kept_internal: assert property (internal_reset_q && !byte_write(cfg_req, csr_off, 2'h1)
      |-> power_state_q == fmpm_pkg::fmpm_d0 ##1 (wake_event_enable_q == $past(wake_event_enable_q)
      && (wake_event_flag || !$past(wake_event_flag))))
    else $error("control state lost at internal reset");

  // Wake flag and fixed control bits
  a_flag_set: assert property (wake_detect |=> wake_event_flag [*1] ##0 csr_word[15])
    else $error("wake flag not set by detection");
  a_flag_hold: assert property (!wake_detect && !wake_event_flag ##1 !wake_detect |-> !wake_event_flag)
    else $error("wake flag set without detection");
  a_csr_zeros: assert property (csr_read |=> cfg_rsp_q.rdata[14:9] == 6'h00)
    else $error("data scale or select not zero");
  a_csr_rsvd: assert property (csr_read |=> cfg_rsp_q.rdata[7:2] == 6'h00)
    else $error("control reserved bits not zero");

  // Register writes
  a_enable_write: assert property (byte_write(cfg_req, csr_off, 2'h1)
      |=> wake_event_enable_q == $past(cfg_req.wdata[8]))
    else $error("wake enable write lost");
  a_state_write: assert property (byte_write(cfg_req, csr_off, 2'h0)
      |=> power_state_q == $past(cfg_req.wdata[1:0]) && cfg_rsp_q.ack)
    else $error("power state write lost");
  a_gctl_write: assert property (byte_write(cfg_req, gctl_off, 2'h0)
      |=> cold_wake_config_q == $past(cfg_req.wdata[4]))
    else $error("general control bit 4 write lost");
  a_flag_clear: assert property (flag_w1c |=> !wake_event_flag ##1 (!wake_event_flag || $past(wake_detect)))
    else $error("wake flag not cleared by write one");

  // Wake output and D3hot exit
  a_wake_gate: assert property (wake_assert_q == (wake_event_flag && wake_event_enable_q))
    else $error("wake output not tied to flag and enable");
  a_exit_pulse: assert property (d3hot_exit
      |-> internal_reset_q ##1 (!internal_reset_q || power_state_q == fmpm_pkg::fmpm_d3hot))
    else $error("internal reset pulse missing on D3hot exit");

  // Reset values, read-back and hold between writes
  a_reset_clear: assert property ($rose(reset_n) |-> !wake_event_flag && !wake_event_enable_q
      && power_state_q == fmpm_pkg::fmpm_d0 && !wake_assert_q && !cold_wake_config_q)
    else $error("fields not cleared by global reset");
  a_gctl_read: assert property (gctl_read |=> cfg_rsp_q.rdata == {27'h0, $past(cold_wake_config_q), 4'h0})
    else $error("general control read wrong");
  a_enable_held: assert property (!byte_write(cfg_req, csr_off, 2'h1) |=> $stable(wake_event_enable_q))
    else $error("wake enable changed without a write");
  a_state_held: assert property (!byte_write(cfg_req, csr_off, 2'h0) |=> $stable(power_state_q))
    else $error("power state changed without a write");
  a_wake_off: assert property (!wake_event_enable_q |-> !wake_assert_q)
    else $error("wake output high while disabled");
  a_flag_read: assert property (csr_read |=> cfg_rsp_q.rdata[15] == $past(wake_event_flag)
      && cfg_rsp_q.rdata[8] == $past(wake_event_enable_q))
    else $error("flag or enable read back wrong");
  a_state_read: assert property (csr_read |=> cfg_rsp_q.rdata[1:0] == $past(power_state_q)
      && cfg_rsp_q.rdata[31:16] == 16'h0000)
    else $error("power state read back wrong");
  a_exit_only: assert property (internal_reset_q |-> $past(power_state_q) == fmpm_pkg::fmpm_d3hot)
    else $error("internal reset without D3hot exit");
  a_set_wins: assert property (wake_detect && flag_clear |=> wake_event_flag)
    else $error("clear won over a new wake event");

endmodule : fmpm_regs

// ===== fmpm_host_model.sv
`timescale 1ns/1ps

module fmpm_host_model (
  input wire logic clk,
  output fmpm_pkg::fmpm_cfg_req_type cfg_req,
  input fmpm_pkg::fmpm_cfg_rsp_type cfg_rsp_q
);
  // Quiet bus before the first access
  initial begin
    cfg_req = '0;
  end

  // One access: request held until the answer edge, then released
  task automatic access(input logic wr, input logic [7:0] addr, input logic [3:0] be,
                        input logic [31:0] wd, output logic [31:0] rd, output logic ack);
    @(negedge clk);
    cfg_req.valid = 1'h1;
    cfg_req.write = wr;
    cfg_req.addr = addr;
    cfg_req.byte_en = be;
    cfg_req.wdata = wd;
    @(negedge clk);
    ack = cfg_rsp_q.ack;
    rd = cfg_rsp_q.rdata;
    // Released address, data and enables show the inverse; write keeps its value
    cfg_req.valid = 1'h0;
    cfg_req.addr = ~addr;
    cfg_req.wdata = ~wd;
    cfg_req.byte_en = ~be;
  endtask : access
endmodule : fmpm_host_model

// ===== tb_fmpm_regs.sv
`timescale 1ns/1ps
`include "fmpm_cfg.svh"

module tb_fmpm_regs;
  logic clk = 1'h0;
  logic reset_n = 1'h0;
  logic wake_detect = 1'h0;
  fmpm_pkg::fmpm_cfg_req_type cfg_req;
  fmpm_pkg::fmpm_cfg_rsp_type cfg_rsp_q;
  logic wake_assert_q;
  fmpm_pkg::fmpm_power_type power_state_q;
  logic internal_reset_q;
  logic cold_wake_config_q;
  int n_fail = 0;
  int checks = 0;
  int seed = 32'h0000_126e;
  logic [31:0] rd;
  logic [31:0] wd;
  logic ack;

  // 250 MHz clock
  always #2 clk = ~clk;

  fmpm_regs fmpm_regs_inst (.clk(clk), .reset_n(reset_n), .cfg_req(cfg_req), .cfg_rsp_q(cfg_rsp_q),
    .wake_detect(wake_detect), .wake_assert_q(wake_assert_q), .power_state_q(power_state_q),
    .internal_reset_q(internal_reset_q), .cold_wake_config_q(cold_wake_config_q));

  fmpm_host_model fmpm_host_model_inst (.clk(clk), .cfg_req(cfg_req), .cfg_rsp_q(cfg_rsp_q));

  // Expected capability dword, upper half
  function automatic logic [31:0] cap_exp(input logic cold);
    cap_exp = {cold, `FMPM_WAKE_MASK, 2'h3, cold ? `FMPM_AUX_55MA : `FMPM_AUX_SELF, 3'h0, `FMPM_SPEC_REV,
               16'h0000};
  endfunction : cap_exp

  // Expected control/status dword
  function automatic logic [31:0] csr_exp(input logic flag, input logic en, input logic [1:0] st);
    csr_exp = {16'h0000, flag, 6'h00, en, 6'h00, st};
  endfunction : csr_exp

  // Compare and report
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Access through the host model, answer always expected
  task automatic acc(input logic w, input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    fmpm_host_model_inst.access(w, a, be, d, rd, ack);
    chk(32'(ack), 32'h0000_0001);
  endtask : acc

  // One wake condition pulse
  task automatic wake_pulse;
    @(negedge clk);
    wake_detect = 1'h1;
    @(negedge clk);
    wake_detect = 1'h0;
  endtask : wake_pulse

  task automatic tally_and_finish;
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // Watchdog against a hang
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'h1;
    acc(1'h0, 8'h44, 4'hf, 32'h0000_0000);
    chk(rd, cap_exp(1'h0));
    acc(1'h0, 8'h48, 4'hf, 32'h0000_0000);
    chk(rd, csr_exp(1'h0, 1'h0, 2'h0));
    acc(1'h1, 8'h44, 4'hf, 32'hffff_ffff);
    acc(1'h1, 8'h4c, 4'h1, 32'h0000_0010);
    chk(32'(cold_wake_config_q), 32'h0000_0001);
    acc(1'h0, 8'h4c, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0010);
    acc(1'h0, 8'h44, 4'hf, 32'h0000_0000);
    chk(rd, cap_exp(1'h1));
    for (int i = 0; i < 16; i++) begin
      wd = $random(seed);
      wd[1:0] = i[1:0];
      acc(1'h1, 8'h48, 4'hf, wd);
      chk(32'(power_state_q), {30'h0, wd[1:0]});
      acc(1'h0, 8'h48, 4'hf, 32'h0000_0000);
      chk(rd, csr_exp(1'h0, wd[8], wd[1:0]));
    end
    acc(1'h1, 8'h48, 4'h2, 32'h0000_0100);
    chk(32'(power_state_q), 32'h0000_0003);
    acc(1'h1, 8'h48, 4'hf, 32'h0000_0000);
    wake_pulse();
    chk(32'(wake_assert_q), 32'h0000_0000);
    acc(1'h1, 8'h48, 4'hf, 32'h0000_0103);
    chk(32'(wake_assert_q), 32'h0000_0001);
    acc(1'h1, 8'h48, 4'h1, 32'h0000_0000);
    chk(32'(internal_reset_q), 32'h0000_0001);
    acc(1'h0, 8'h48, 4'hf, 32'h0000_0000);
    chk(rd, csr_exp(1'h1, 1'h1, 2'h0));
    fork
      acc(1'h1, 8'h48, 4'h2, 32'h0000_8100);
      wake_pulse();
    join
    chk(32'(wake_assert_q), 32'h0000_0001);
    acc(1'h1, 8'h48, 4'h2, 32'h0000_8100);
    chk(32'(wake_assert_q), 32'h0000_0000);
    // Unmapped dword ignores writes
    acc(1'h1, 8'h50, 4'hf, 32'hffff_ffff);
    acc(1'h0, 8'h50, 4'hf, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    acc(1'h1, 8'h48, 4'hf, 32'h0000_0102);
    wake_pulse();
    reset_n = 1'h0;
    repeat (2) @(negedge clk);
    reset_n = 1'h1;
    chk(32'(power_state_q), 32'h0000_0000);
    acc(1'h0, 8'h48, 4'hf, 32'h0000_0000);
    chk(rd, csr_exp(1'h0, 1'h0, 2'h0));
    acc(1'h0, 8'h44, 4'hf, 32'h0000_0000);
    chk(rd, cap_exp(1'h0));
    tally_and_finish();
  end
endmodule : tb_fmpm_regs
